// ===== hw/vdc_regs.sv
// Control register bank of a video decoder with an AXI4-Lite slave port.
// Assumes a 20 MHz clock_i that also paces the line sync pixel count.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "vdc_params.svh"

module vdc_regs #(
	parameter int ADDR_W = `VDC_ADDR_W
) (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic subcarrier_lock_bit_i,
	input wire logic line_sync_fall_i,
	output logic realtime_control_output_o,
	output logic line_sync_o
);

	////////////////////////////////////////////////////////////////////////////
	// Register table and decoding.

	localparam logic [15:0] VDC_TABLE [`VDC_NUM_REGS] = '{
		`VDC_REG_INPUT_SELECT,
		`VDC_REG_VIDEO_STANDARD_SELECT,
		`VDC_REG_PICTURE_ENHANCEMENT,
		`VDC_REG_OUTPUT_FORMAT,
		`VDC_REG_OUTPUT_FORMAT_EXT,
		`VDC_REG_SPARE_OUTPUTS,
		`VDC_REG_OUTPUT_QUEUE_SETUP,
		`VDC_REG_CONTRAST_LEVEL,
		`VDC_REG_SATURATION_LEVEL,
		`VDC_REG_BRIGHTNESS_LEVEL,
		`VDC_REG_HUE_LEVEL,
		`VDC_REG_LUMA_FILL_VALUE,
		`VDC_REG_CHROMA_FILL_VALUE,
		`VDC_REG_FIELD_DROP_SETUP,
		`VDC_REG_POWER_MODES,
		`VDC_REG_DECODER_STATE,
		`VDC_REG_DECODER_INFO,
		`VDC_REG_ANALOG_INTERNAL,
		`VDC_REG_ANALOG_CLAMP,
		`VDC_REG_DIGITAL_CLAMP_A,
		`VDC_REG_DIGITAL_CLAMP_B,
		`VDC_REG_SHAPING_FILTER,
		`VDC_REG_COMB_FILTER,
		`VDC_REG_SUBCARRIER_A,
		`VDC_REG_MANUAL_CLOCK_A,
		`VDC_REG_MANUAL_CLOCK_B,
		`VDC_REG_MANUAL_CLOCK_C,
		`VDC_REG_AUTOMATIC_CLOCKING,
		`VDC_REG_GAIN_LOOP_MODE,
		`VDC_REG_CHROMA_GAIN_A,
		`VDC_REG_CHROMA_GAIN_B,
		`VDC_REG_LUMA_GAIN_A,
		`VDC_REG_LUMA_GAIN_B,
		`VDC_REG_GAIN_SHADOW_A,
		`VDC_REG_GAIN_SHADOW_B,
		`VDC_REG_GAIN_MISC,
		`VDC_REG_LINE_SYNC_POSITION_A,
		`VDC_REG_LINE_SYNC_POSITION_B,
		`VDC_REG_LINE_SYNC_POSITION_C,
		`VDC_REG_SIGNAL_POLARITIES,
		`VDC_REG_RESAMPLE_SETUP,
		`VDC_REG_FIXED_PATTERN_A,
		`VDC_REG_FIXED_PATTERN_B,
		`VDC_REG_FIXED_PATTERN_C
	};

	// Maps a register index to presence, access and reset value; used at elaboration and on both bus paths.
	function automatic vdc_pkg::vdc_slot_t vdc_lookup(input logic [7:0] idx);
		vdc_lookup = '{hit: 1'b0, ro: 1'b0, rst: 8'h00};
		for (int i = 0; i < `VDC_NUM_REGS; i++) begin
			if (VDC_TABLE[i][15:8] == idx) begin
				vdc_lookup.hit = 1'b1;
				vdc_lookup.rst = VDC_TABLE[i][7:0];
			end
		end
		vdc_lookup.ro = (idx == `VDC_OFS_STATE) || (idx == `VDC_OFS_INFO);
	endfunction : vdc_lookup

	// The index sits above the two byte-offset bits, so a narrower address bus cannot reach 0xF2.
	if (ADDR_W < `VDC_ADDR_W) begin : g_bad_width
		$error("ADDR_W too small for the register map");
	end

	////////////////////////////////////////////////////////////////////////////
	// Reset release.

	logic rst_meta_reg;
	logic rst_n;

	// Assertion is immediate, release waits two edges so no flop leaves reset on a partial edge.
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write channel.

	logic [7:0] wr_idx_reg;
	logic [7:0] wr_data_reg;
	logic wr_lane_reg;
	logic have_aw_reg;
	logic have_w_reg;
	logic wr_do;
	vdc_pkg::vdc_slot_t wr_slot;

	assign wr_do = have_aw_reg && have_w_reg && !s_axi_bvalid_o;
	assign wr_slot = vdc_lookup(wr_idx_reg);

	// Address and data are captured independently, in either order.
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			have_aw_reg <= 1'b0;
			wr_idx_reg <= 8'h00;
			s_axi_awready_o <= 1'b1;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			have_aw_reg <= 1'b1;
			wr_idx_reg <= s_axi_awaddr_i[9:2];
			s_axi_awready_o <= 1'b0;
		end else if (s_axi_bvalid_o && s_axi_bready_i) begin
			have_aw_reg <= 1'b0;
			s_axi_awready_o <= 1'b1;
		end
	end

	// Only byte lane 0 carries register data; other lanes are ignored.
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			have_w_reg <= 1'b0;
			wr_data_reg <= 8'h00;
			wr_lane_reg <= 1'b0;
			s_axi_wready_o <= 1'b1;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			have_w_reg <= 1'b1;
			wr_data_reg <= s_axi_wdata_i[7:0];
			wr_lane_reg <= s_axi_wstrb_i[0];
			s_axi_wready_o <= 1'b0;
		end else if (s_axi_bvalid_o && s_axi_bready_i) begin
			have_w_reg <= 1'b0;
			s_axi_wready_o <= 1'b1;
		end
	end

	// Response follows both halves; unmapped indices answer SLVERR.
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `VDC_RESP_OKAY;
		end else if (wr_do) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o <= wr_slot.hit ? `VDC_RESP_OKAY : `VDC_RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register storage, one flop byte per mapped writable index.

	logic [7:0] mem [256];

	for (genvar g = 0; g < 256; g++) begin : g_mem
		localparam vdc_pkg::vdc_slot_t SLOT = vdc_lookup(8'(g));
		if (SLOT.hit && !SLOT.ro) begin : g_flop
			logic [7:0] cell_reg;

			// Undefined reset bits come up as zero so the block never starts unknown.
			always_ff @(posedge clock_i or negedge rst_n) begin
				if (!rst_n) begin
					cell_reg <= SLOT.rst;
				end else if (wr_do && wr_lane_reg && wr_idx_reg == 8'(g)) begin
					cell_reg <= wr_data_reg;
				end
			end

			// Each array element has exactly one driver: here a plain continuous copy of its cell, in g_none a constant zero.
			assign mem[g] = cell_reg;
		end else begin : g_none
			assign mem[g] = 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read channel.

	vdc_pkg::vdc_state_t state;
	vdc_pkg::vdc_slot_t rd_slot;
	logic [9:0] cnt_reg;
	logic [7:0] rd_idx;
	logic [7:0] rd_byte;

	assign state = '{zero: 6'h00, line_sync: line_sync_o, realtime_out: realtime_control_output_o};
	assign rd_idx = s_axi_araddr_i[9:2];
	assign rd_slot = vdc_lookup(rd_idx);

	// Status shows live outputs; info shows the low bits of the pixel count.
	always_comb begin
		case (rd_idx)
			`VDC_OFS_STATE: rd_byte = state;
			`VDC_OFS_INFO: rd_byte = cnt_reg[7:0];
			default: rd_byte = mem[rd_idx];
		endcase
	end

	// One read at a time; data is answered the edge after the address is taken.
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= `VDC_RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= {24'h00_0000, rd_slot.hit ? rd_byte : 8'h00};
			s_axi_rresp_o <= rd_slot.hit ? `VDC_RESP_OKAY : `VDC_RESP_SLVERR;
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Realtime control output.

	logic flip;

	assign flip = mem[`VDC_OFS_RESAMPLE][`VDC_FLIP_BIT];

	// Registered so the output pin never sees a glitch from the register write.
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			realtime_control_output_o <= 1'b0;
		end else begin
			realtime_control_output_o <= subcarrier_lock_bit_i ^ flip;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Line sync generator.

	logic run_reg;
	logic [9:0] line_sync_begin_count;
	logic [9:0] line_sync_end_count;
	logic active;
	logic pol;

	assign line_sync_begin_count = {mem[`VDC_OFS_LSYNC_A][7:6], mem[`VDC_OFS_LSYNC_B]};
	assign line_sync_end_count = {mem[`VDC_OFS_LSYNC_A][5:4], mem[`VDC_OFS_LSYNC_C]};
	assign pol = mem[`VDC_OFS_POLARITIES][`VDC_POL_LSYNC_BIT];
	assign active = run_reg && cnt_reg >= line_sync_begin_count && cnt_reg < line_sync_end_count;

	// Counts pixels from the incoming fall; saturates so a lost sync cannot wrap into a new pulse.
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			run_reg <= 1'b0;
			cnt_reg <= 10'h000;
		end else if (line_sync_fall_i) begin
			run_reg <= 1'b1;
			cnt_reg <= 10'h000;
		end else if (run_reg && cnt_reg != 10'h3FF) begin
			cnt_reg <= cnt_reg + 10'h001;
		end
	end

	// Polarity register bit 7 chooses an active-low pulse.
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			line_sync_o <= 1'b0;
		end else begin
			line_sync_o <= active ^ pol;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n);

	sequence s_released;
		$rose(rst_n);
	endsequence

	sequence s_count_zero;
		cnt_reg == 10'h000 && run_reg;
	endsequence

	// The first cycle after release is skipped: its output was still loaded by reset.
	AST_REALTIME_CONTROL_OUTPUT_FLIP: assert property ($past(rst_n) |->
		realtime_control_output_o == ($past(subcarrier_lock_bit_i) ^ $past(flip)))
		else $error("realtime output does not follow lock bit and flip");
	AST_FLIP_HOLD: assert property (!wr_do |=> $stable(flip))
		else $error("inversion bit changed without a write");
	AST_CLAMP_RST: assert property (s_released |-> mem[`VDC_OFS_CLAMP_A][7:4] == `VDC_RST_CLAMP_A_HI)
		else $error("clamp register reset nibble wrong");
	AST_SUBCARRIER_RST: assert property (s_released |-> mem[`VDC_OFS_SUBCARRIER_A][7:4] == `VDC_RST_SUBCARRIER_A_HI)
		else $error("subcarrier register reset nibble wrong");
	AST_LSYNC_RST: assert property (s_released |-> {mem[`VDC_OFS_LSYNC_A], mem[`VDC_OFS_LSYNC_B],
		mem[`VDC_OFS_LSYNC_C]} == {`VDC_RST_LSYNC_A, `VDC_RST_LSYNC_B, `VDC_RST_LSYNC_C})
		else $error("line sync position reset values wrong");
	AST_SHADOW_RST: assert property (s_released |-> mem[`VDC_OFS_SHADOW_A][7:4] == `VDC_RST_SHADOW_A_HI)
		else $error("gain shadow reset nibble wrong");
	AST_CHROMA_RST: assert property (s_released |-> mem[`VDC_OFS_CHROMA_GAIN_A][7:4] == `VDC_RST_CHROMA_GAIN_A_HI)
		else $error("chroma gain reset nibble wrong");
	AST_SYNC_RESTART: assert property (line_sync_fall_i |=> s_count_zero
		##1 (cnt_reg == 10'h001 || $past(line_sync_fall_i)))
		else $error("pixel count did not start at the incoming fall");
	AST_SYNC_BEGIN: assert property (run_reg && cnt_reg == line_sync_begin_count
		&& line_sync_begin_count < line_sync_end_count |=> line_sync_o != $past(pol))
		else $error("line sync did not start at the begin count");
	AST_SYNC_END: assert property (run_reg && cnt_reg == line_sync_end_count |=> line_sync_o == $past(pol))
		else $error("line sync did not end at the end count");
	AST_READ_LATENCY: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read data not answered in one cycle");

endmodule : vdc_regs

// ===== shared/vdc_params.svh
// Constants of the video decoder control register bank: offsets, reset values, fields.
// Assumes byte-wide registers placed one per 32-bit word (byte address = 4 * index).
`ifndef VDC_PARAMS_SVH
`define VDC_PARAMS_SVH

`define VDC_ADDR_W 10
`define VDC_RESP_OKAY 2'h0
`define VDC_RESP_SLVERR 2'h2
`define VDC_NUM_REGS 44
`define VDC_FLIP_BIT 6
`define VDC_POL_LSYNC_BIT 7
`define VDC_OFS_STATE 8'h10
`define VDC_OFS_INFO 8'h11
`define VDC_OFS_CLAMP_A 8'h15
`define VDC_OFS_SUBCARRIER_A 8'h23
`define VDC_OFS_CHROMA_GAIN_A 8'h2D
`define VDC_OFS_SHADOW_A 8'h31
`define VDC_OFS_LSYNC_A 8'h34
`define VDC_OFS_LSYNC_B 8'h35
`define VDC_OFS_LSYNC_C 8'h36
`define VDC_OFS_POLARITIES 8'h37
`define VDC_OFS_RESAMPLE 8'h44
// Upper nibbles of the registers whose low nibble has no defined power-on value, then the full line sync position reset bytes.
`define VDC_RST_CLAMP_A_HI 4'h6
`define VDC_RST_SUBCARRIER_A_HI 4'hE
`define VDC_RST_SHADOW_A_HI 4'h7
`define VDC_RST_CHROMA_GAIN_A_HI 4'hF
`define VDC_RST_LSYNC_A 8'h0F
`define VDC_RST_LSYNC_B 8'h01
`define VDC_RST_LSYNC_C 8'h00
// Each table entry is {index, reset value}; undefined reset bits are loaded as zero.
`define VDC_REG_INPUT_SELECT {8'h00, 8'h00}
`define VDC_REG_VIDEO_STANDARD_SELECT {8'h01, 8'h80}
`define VDC_REG_PICTURE_ENHANCEMENT {8'h02, 8'h04}
`define VDC_REG_OUTPUT_FORMAT {8'h03, 8'h0C}
`define VDC_REG_OUTPUT_FORMAT_EXT {8'h04, 8'h0C}
`define VDC_REG_SPARE_OUTPUTS {8'h05, 8'h40}
`define VDC_REG_OUTPUT_QUEUE_SETUP {8'h07, 8'h04}
`define VDC_REG_CONTRAST_LEVEL {8'h08, 8'h80}
`define VDC_REG_SATURATION_LEVEL {8'h09, 8'h80}
`define VDC_REG_BRIGHTNESS_LEVEL {8'h0A, 8'h00}
`define VDC_REG_HUE_LEVEL {8'h0B, 8'h00}
`define VDC_REG_LUMA_FILL_VALUE {8'h0C, 8'h10}
`define VDC_REG_CHROMA_FILL_VALUE {8'h0D, 8'h88}
`define VDC_REG_FIELD_DROP_SETUP {8'h0E, 8'h00}
`define VDC_REG_POWER_MODES {8'h0F, 8'h00}
`define VDC_REG_DECODER_STATE {`VDC_OFS_STATE, 8'h00}
`define VDC_REG_DECODER_INFO {`VDC_OFS_INFO, 8'h00}
`define VDC_REG_ANALOG_INTERNAL {8'h13, 8'h45}
`define VDC_REG_ANALOG_CLAMP {8'h14, 8'h18}
`define VDC_REG_DIGITAL_CLAMP_A {`VDC_OFS_CLAMP_A, `VDC_RST_CLAMP_A_HI, 4'h0}
`define VDC_REG_DIGITAL_CLAMP_B {8'h16, 8'h00}
`define VDC_REG_SHAPING_FILTER {8'h17, 8'h01}
`define VDC_REG_COMB_FILTER {8'h19, 8'h10}
`define VDC_REG_SUBCARRIER_A {`VDC_OFS_SUBCARRIER_A, `VDC_RST_SUBCARRIER_A_HI, 4'h0}
`define VDC_REG_MANUAL_CLOCK_A {8'h28, 8'h00}
`define VDC_REG_MANUAL_CLOCK_B {8'h29, 8'h00}
`define VDC_REG_MANUAL_CLOCK_C {8'h2A, 8'h00}
`define VDC_REG_AUTOMATIC_CLOCKING {8'h2B, 8'hA0}
`define VDC_REG_GAIN_LOOP_MODE {8'h2C, 8'hCE}
`define VDC_REG_CHROMA_GAIN_A {`VDC_OFS_CHROMA_GAIN_A, `VDC_RST_CHROMA_GAIN_A_HI, 4'h0}
`define VDC_REG_CHROMA_GAIN_B {8'h2E, 8'h00}
`define VDC_REG_LUMA_GAIN_A {8'h2F, 8'h00}
`define VDC_REG_LUMA_GAIN_B {8'h30, 8'h00}
`define VDC_REG_GAIN_SHADOW_A {`VDC_OFS_SHADOW_A, `VDC_RST_SHADOW_A_HI, 4'h0}
`define VDC_REG_GAIN_SHADOW_B {8'h32, 8'h00}
`define VDC_REG_GAIN_MISC {8'h33, 8'hE3}
`define VDC_REG_LINE_SYNC_POSITION_A {`VDC_OFS_LSYNC_A, `VDC_RST_LSYNC_A}
`define VDC_REG_LINE_SYNC_POSITION_B {`VDC_OFS_LSYNC_B, `VDC_RST_LSYNC_B}
`define VDC_REG_LINE_SYNC_POSITION_C {`VDC_OFS_LSYNC_C, `VDC_RST_LSYNC_C}
`define VDC_REG_SIGNAL_POLARITIES {`VDC_OFS_POLARITIES, 8'h00}
`define VDC_REG_RESAMPLE_SETUP {`VDC_OFS_RESAMPLE, 8'h01}
`define VDC_REG_FIXED_PATTERN_A {8'h45, 8'h23}
`define VDC_REG_FIXED_PATTERN_B {8'hF1, 8'hF6}
`define VDC_REG_FIXED_PATTERN_C {8'hF2, 8'h9C}

`endif

// ===== shared/vdc_pkg.sv
// Types of the video decoder control register bank.
// Assumes the constants of vdc_params.svh are included by the user.
package vdc_pkg;

	// Result of decoding one register index.
	typedef struct packed {
		logic hit;
		logic ro;
		logic [7:0] rst;
	} vdc_slot_t;

	// Live state that the status register reports.
	typedef struct packed {
		logic [5:0] zero;
		logic line_sync;
		logic realtime_out;
	} vdc_state_t;

endpackage : vdc_pkg

// ===== testbench/vdc_host_model.sv
// Host processor model: an AXI4-Lite master that programs the decoder registers.
// Assumes one clock shared with the register bank and byte address = 4 * register index.
`timescale 1ns/1ps
module vdc_host_model (
	input wire logic clock_i,
	output logic [9:0] awaddr_o,
	output logic awvalid_o,
	input wire logic awready_i,
	output logic [31:0] wdata_o,
	output logic [3:0] wstrb_o,
	output logic wvalid_o,
	input wire logic wready_i,
	input wire logic [1:0] bresp_i,
	input wire logic bvalid_i,
	output logic bready_o,
	output logic [9:0] araddr_o,
	output logic arvalid_o,
	input wire logic arready_i,
	input wire logic [31:0] rdata_i,
	input wire logic [1:0] rresp_i,
	input wire logic rvalid_i,
	output logic rready_o
);
	////////////////////////////////////////
	// Idle bus; released payloads are inverted so a stale value is never mistaken for a live one.
	initial begin
		{awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
		{araddr_o, arvalid_o, rready_o} = '0;
	end

	// One write: address and data offered together, each released when taken.
	task automatic write_reg(input logic [7:0] idx, input logic [7:0] val, output logic [1:0] resp);
		logic aw_left;
		logic w_left;
		aw_left = 1'b1;
		w_left = 1'b1;
		@(posedge clock_i);
		awaddr_o <= {idx, 2'h0};
		awvalid_o <= 1'b1;
		wdata_o <= {24'h000000, val};
		wstrb_o <= 4'hF;
		wvalid_o <= 1'b1;
		bready_o <= 1'b1;
		forever begin
			@(posedge clock_i);
			if (aw_left && awready_i) begin
				aw_left = 1'b0;
				awvalid_o <= 1'b0;
				awaddr_o <= ~awaddr_o;
			end
			if (w_left && wready_i) begin
				w_left = 1'b0;
				wvalid_o <= 1'b0;
				wdata_o <= ~wdata_o;
			end
			if (!aw_left && !w_left && bvalid_i) break;
		end
		resp = bresp_i;
		bready_o <= 1'b0;
	endtask : write_reg

	// One read: the answer is taken at the edge where rvalid is seen with rready high.
	task automatic read_reg(input logic [7:0] idx, output logic [31:0] data, output logic [1:0] resp);
		@(posedge clock_i);
		araddr_o <= {idx, 2'h0};
		arvalid_o <= 1'b1;
		rready_o <= 1'b1;
		forever begin
			@(posedge clock_i);
			if (arvalid_o && arready_i) begin
				arvalid_o <= 1'b0;
				araddr_o <= ~araddr_o;
			end
			if (rvalid_i) break;
		end
		data = rdata_i;
		resp = rresp_i;
		rready_o <= 1'b0;
	endtask : read_reg

	// Mandatory set-up that software owes the device before relying on it.
	task automatic program_fixed(input logic flip);
		logic [1:0] resp;
		write_reg(8'h44, {1'b0, flip, 6'h01}, resp);
		write_reg(8'h45, 8'hBB, resp);
		write_reg(8'hF1, 8'hEF, resp);
		write_reg(8'hF2, 8'h80, resp);
	endtask : program_fixed
endmodule : vdc_host_model

// ===== testbench/video_decoder_config_reset_map_test.sv
// Self-checking bench of the decoder control register bank, driven by the host model.
// Assumes the bank answers on AXI4-Lite and one clock of 20 MHz.
`timescale 1ns/1ps
module video_decoder_config_reset_map_test;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic lock_bit = 1'b0;
	logic sync_fall = 1'b0;
	logic rt_out;
	logic lsync_out;
	logic [9:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata_w, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	int fail_count = 0;
	int n_compared = 0;

	////////////////////////////////////////
	// Clock of 50 ns period.
	always #25 clock = ~clock;

	vdc_regs dut (.clock_i(clock), .nrst_i(nrst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata_w), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.subcarrier_lock_bit_i(lock_bit), .line_sync_fall_i(sync_fall),
		.realtime_control_output_o(rt_out), .line_sync_o(lsync_out));

	vdc_host_model host (.clock_i(clock), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
		.wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
		.bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready),
		.rdata_i(rdata_w), .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));

	////////////////////////////////////////
	// Compare one value and count it.
	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask : compare

	// Read a register and compare the masked byte; the response must be OKAY.
	task automatic check_read(input logic [7:0] idx, input logic [7:0] mask, input logic [7:0] exp);
		host.read_reg(idx, rdata, resp);
		compare(rdata & {24'h000000, mask}, {24'h000000, exp});
		compare({30'h0, resp}, 32'h0);
	endtask : check_read

	// Power-on values, masked where the low nibble has no defined value.
	task automatic test_reset();
		logic [23:0] tab [0:9];
		tab = '{24'h15F060, 24'h23F0E0, 24'h34FF0F, 24'h35FF01, 24'h36FF00,
			24'h31F070, 24'h2DF0F0, 24'h01FF80, 24'h33FFE3, 24'h2BFFA0};
		for (int i = 0; i < 10; i++) begin
			check_read(tab[i][23:16], tab[i][15:8], tab[i][7:0]);
		end
		$display("test reset values done");
	endtask : test_reset

	// Write and read back, then an unmapped index in both directions.
	task automatic test_access();
		host.write_reg(8'h08, 8'h5A, resp);
		compare({30'h0, resp}, 32'h0);
		check_read(8'h08, 8'hFF, 8'h5A);
		host.write_reg(8'h50, 8'hA5, resp);
		compare({30'h0, resp}, 32'h2);
		host.read_reg(8'h50, rdata, resp);
		compare(rdata, 32'h0);
		compare({30'h0, resp}, 32'h2);
		$display("test access done");
	endtask : test_access

	// Required patterns are stored as the host writes them.
	task automatic test_fixed();
		host.program_fixed(1'b0);
		check_read(8'h44, 8'hFF, 8'h01);
		check_read(8'h45, 8'hFF, 8'hBB);
		check_read(8'hF1, 8'hFF, 8'hEF);
		check_read(8'hF2, 8'hFF, 8'h80);
		$display("test fixed patterns done");
	endtask : test_fixed

	// Every pairing of inversion bit and lock level; the bit is written before use.
	task automatic test_flip();
		for (int f = 0; f < 2; f++) begin
			host.program_fixed(f[0]);
			for (int l = 0; l < 2; l++) begin
				@(posedge clock);
				lock_bit <= l[0];
				repeat (3) @(posedge clock);
				compare({31'h0, rt_out}, {31'h0, l[0] ^ f[0]});
				check_read(8'h10, 8'h01, {7'h00, l[0] ^ f[0]});
			end
		end
		$display("test lock inversion done");
	endtask : test_flip

	// Pulse width in pixels equals end minus begin, for both polarities; none when begin >= end.
	task automatic test_lsync();
		logic [23:0] tab [0:3];
		int hits;
		tab = '{24'h010000, 24'h020500, 24'h020580, 24'h040400};
		for (int i = 0; i < 4; i++) begin
			host.write_reg(8'h35, tab[i][23:16], resp);
			host.write_reg(8'h36, tab[i][15:8], resp);
			host.write_reg(8'h37, tab[i][7:0], resp);
			hits = 0;
			@(posedge clock);
			sync_fall <= 1'b1;
			@(posedge clock);
			sync_fall <= 1'b0;
			repeat (40) begin
				@(posedge clock);
				if ((lsync_out ^ tab[i][7]) === 1'b1) hits++;
			end
			compare(32'(hits), (tab[i][15:8] > tab[i][23:16]) ? 32'(tab[i][15:8] - tab[i][23:16]) : 32'h0);
		end
		$display("test line sync done");
	endtask : test_lsync

	// Print the counts and the verdict, then stop.
	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test

	////////////////////////////////////////
	// Main sequence: reset for 20 cycles, settle, the tests, then a mid-run reset that must restore defaults.
	initial begin
		repeat (20) @(posedge clock);
		nrst <= 1'b1;
		repeat (4) @(posedge clock);
		test_reset();
		test_access();
		test_fixed();
		test_flip();
		test_lsync();
		@(posedge clock);
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		repeat (4) @(posedge clock);
		test_reset();
		finish_test();
	end

	// Watchdog: the tests need well under 2000 cycles, so 4000 means a hang.
	initial begin
		#200000;
		fail_count++;
		finish_test();
	end
endmodule : video_decoder_config_reset_map_test
